// file: logic/lsh_cfg.svh
`ifndef LSH_CFG_SVH
`define LSH_CFG_SVH

// -----------------------------------------------------------------
// Register offsets (byte addresses)
// -----------------------------------------------------------------
`define LSH_OFF_CTRL      8'h00
`define LSH_OFF_STATUS    8'h04
`define LSH_OFF_IRQ_STS   8'h08
`define LSH_OFF_IRQ_MASK  8'h0c

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define LSH_ST_DROPOUT    8
`define LSH_ST_SETTLED    9
`define LSH_ST_OFFHOOK    10
`define LSH_IRQ_W         4
`define LSH_IRQ_SETTLED   0
`define LSH_IRQ_OVERLOAD  1
`define LSH_IRQ_DROPOUT   2
`define LSH_IRQ_CHANGE    3

// -----------------------------------------------------------------
// Reset values and thresholds
// -----------------------------------------------------------------
`define LSH_CTRL_RESET    8'h10
`define LSH_V_ZERO_Q      9'h00c
`define LSH_V_STEP_Q      9'h00b
`define LSH_I_STEP_MA     8'h03
`define LSH_I_MAX_STEP    8'h1e
`define LSH_OVL_STD_MA    8'h8c
`define LSH_OVL_CTR21_MA  8'h36
`define LSH_CODE_OVL      5'h1f
`define LSH_CODE_MAX      5'h1f
`define LSH_SETTLE_FS     1548
`define LSH_RESP_OKAY     2'h0
`define LSH_RESP_SLVERR   2'h2
`endif

// file: logic/lsh_pkg.sv
package lsh_pkg;
  // DC termination modes
  typedef enum logic [1:0] {
    LSH_DCT_LOWV  = 2'h0,
    LSH_DCT_JAPAN = 2'h1,
    LSH_DCT_FCC   = 2'h2,
    LSH_DCT_CTR21 = 2'h3
  } lsh_dct_t;

  // Transmit full-scale level picked by the termination mode
  typedef enum logic [1:0] {
    LSH_TX_M1DBM   = 2'h0,
    LSH_TX_M271DBM = 2'h1,
    LSH_TX_M5DBM   = 2'h2
  } lsh_txfs_t;

  // Hook sequencer, one-hot
  typedef enum logic [2:0] {
    LSH_ONHOOK   = 3'h1,
    LSH_SETTLING = 3'h2,
    LSH_READY    = 3'h4
  } lsh_hook_t;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic     ac_termination_select;
    logic     low_voltage_trim;
    logic     current_limit_enable;
    lsh_dct_t dc_termination_select;
    logic     onhook_monitor_enable;
    logic     report_mode;
    logic     hook_seize;
  } lsh_ctrl_t;

  // Drive towards the line-side analog circuits
  typedef struct packed {
    logic      hook_switch_on;
    lsh_dct_t  dc_termination_select;
    logic      current_limit_on;
    logic      low_voltage_trim;
    logic      ac_term_complex;
    lsh_txfs_t tx_full_scale;
  } lsh_line_ctl_t;
endpackage

// file: logic/lsh_line_sense.sv
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "lsh_cfg.svh"
module lsh_line_sense #(
  parameter int SETTLE_SAMPLES = `LSH_SETTLE_FS
) (
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  // AXI4-Lite slave
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Line-side measurement pins
  input  wire logic [8:0]             line_volt_qv,
  input  wire logic [7:0]             loop_current_ma,
  input  wire logic                   line_present,
  input  wire logic                   sample_tick,
  // Line-side control and host side
  output lsh_pkg::lsh_line_ctl_t      line_ctl,
  output logic                        line_data_valid,
  output logic                        irq
);
  import lsh_pkg::*;

  localparam logic [10:0] SETTLE_N = 11'(SETTLE_SAMPLES);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [8:0] volt_s1_r, volt_s2_r;
  logic [7:0] cur_s1_r, cur_s2_r;
  logic       pres_s1_r, pres_s2_r;
  logic       tick_s1_r, tick_s2_r, tick_s3_r;

  // Two stages each, three on the strobe; the first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    volt_s1_r <= line_volt_qv;
    volt_s2_r <= volt_s1_r;
    cur_s1_r  <= loop_current_ma;
    cur_s2_r  <= cur_s1_r;
    pres_s1_r <= line_present;
    pres_s2_r <= pres_s1_r;
    tick_s1_r <= sample_tick;
    tick_s2_r <= tick_s1_r;
    tick_s3_r <= tick_s2_r;
  end

  logic tick_rise;
  assign tick_rise = tick_s2_r & ~tick_s3_r; // Edge seen on settled stages only

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  lsh_ctrl_t             ctrl_r, ctrl_nxt;
  logic [`LSH_IRQ_W-1:0] irq_sts_r, irq_sts_nxt;
  logic [`LSH_IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
  lsh_hook_t             hook_r, hook_nxt;
  logic [10:0]           settle_cnt_r, settle_cnt_nxt;
  logic [4:0]            code_r, code_nxt;
  logic                  ovl_r, ovl_nxt;
  logic                  drop_r, drop_nxt;

  // ---------------------------------------------------------------
  // Measurement to code conversion
  // ---------------------------------------------------------------
  logic       offhook;
  logic [4:0] volt_code, cur_code;
  logic       overload;
  logic [8:0] vq_over;
  logic [7:0] i_steps, ovl_lim;

  // Voltage arrives in quarter volts: 3 V is 12, one 2.75 V step is 11
  always_comb begin
    vq_over = volt_s2_r - `LSH_V_ZERO_Q;
    if (volt_s2_r < `LSH_V_ZERO_Q) begin
      volt_code = 5'h00;
    end else if ((vq_over / `LSH_V_STEP_Q) >= 9'(`LSH_CODE_MAX)) begin
      volt_code = `LSH_CODE_MAX; // Clip at the 87 V full scale
    end else begin
      volt_code = 5'(vq_over / `LSH_V_STEP_Q) + 5'h01;
    end
  end

  // Loop current in 3 mA steps; the overload limit depends on mode
  always_comb begin
    ovl_lim  = (ctrl_r.dc_termination_select == LSH_DCT_CTR21) ?
               `LSH_OVL_CTR21_MA : `LSH_OVL_STD_MA;
    overload = cur_s2_r > ovl_lim;
    i_steps  = cur_s2_r / `LSH_I_STEP_MA;
    if (overload) begin
      cur_code = `LSH_CODE_OVL;
    end else if (i_steps > `LSH_I_MAX_STEP) begin
      cur_code = 5'(`LSH_I_MAX_STEP); // Keep 11111 for overload only
    end else begin
      cur_code = 5'(i_steps); // zero below one step, one at minimum
    end
  end

  assign offhook = (hook_r != LSH_ONHOOK);

  // ---------------------------------------------------------------
  // Line control outputs
  // ---------------------------------------------------------------
  always_comb begin
    line_ctl.hook_switch_on        = offhook;
    line_ctl.dc_termination_select = ctrl_r.dc_termination_select;
    line_ctl.current_limit_on      = ctrl_r.current_limit_enable &
      (ctrl_r.dc_termination_select == LSH_DCT_CTR21);
    line_ctl.low_voltage_trim      = ctrl_r.low_voltage_trim;
    line_ctl.ac_term_complex       = ctrl_r.ac_termination_select;
    case (ctrl_r.dc_termination_select)
      LSH_DCT_LOWV:  line_ctl.tx_full_scale = LSH_TX_M5DBM;
      LSH_DCT_JAPAN: line_ctl.tx_full_scale = LSH_TX_M271DBM;
      LSH_DCT_FCC:   line_ctl.tx_full_scale = LSH_TX_M1DBM;
      default:       line_ctl.tx_full_scale = LSH_TX_M1DBM;
    endcase
  end

  assign line_data_valid = (hook_r == LSH_READY);

  // ---------------------------------------------------------------
  // Hook sequencer and line-sense code
  // ---------------------------------------------------------------
  logic [`LSH_IRQ_W-1:0] events;

  // Settling counts sample periods, so it follows whatever rate is set
  always_comb begin
    hook_nxt       = hook_r;
    settle_cnt_nxt = settle_cnt_r;
    case (hook_r)
      LSH_ONHOOK: begin
        settle_cnt_nxt = 11'h000;
        if (ctrl_r.hook_seize) begin
          hook_nxt = LSH_SETTLING;
        end
      end
      LSH_SETTLING: begin
        if (!ctrl_r.hook_seize) begin
          hook_nxt = LSH_ONHOOK;
        end else if (tick_rise) begin
          settle_cnt_nxt = settle_cnt_r + 11'h001;
          if (settle_cnt_r + 11'h001 >= SETTLE_N) begin
            hook_nxt = LSH_READY;
          end
        end
      end
      LSH_READY: begin
        if (!ctrl_r.hook_seize) begin
          hook_nxt = LSH_ONHOOK;
        end
      end
      default: begin
        hook_nxt = LSH_ONHOOK;
      end
    endcase

    // Code tracks the live measurement every cycle, zero on-hook with both report and monitor off; never software
    if (offhook) begin
      code_nxt = cur_code;
    end else if (ctrl_r.report_mode) begin
      code_nxt = volt_code;
    end else if (ctrl_r.onhook_monitor_enable) begin
      code_nxt = cur_code;
    end else begin
      code_nxt = 5'h00;
    end
    ovl_nxt  = overload & offhook;
    drop_nxt = ~pres_s2_r;

    events = '0;
    events[`LSH_IRQ_SETTLED]  = (hook_r == LSH_SETTLING) & (hook_nxt == LSH_READY);
    events[`LSH_IRQ_OVERLOAD] = ovl_nxt & ~ovl_r;
    events[`LSH_IRQ_DROPOUT]  = drop_nxt & ~drop_r;
    events[`LSH_IRQ_CHANGE]   = code_nxt != code_r;
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic        aw_full_r, aw_full_nxt;
  logic        w_full_r, w_full_nxt;
  logic [7:0]  aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic        w_strb0_r, w_strb0_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        do_write;

  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready  = ~w_full_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign do_write      = aw_full_r & w_full_r & ~bvalid_r;
  assign irq           = |(irq_sts_r & irq_mask_r);

  // Address and data are caught separately, so either may come first
  always_comb begin
    aw_full_nxt  = aw_full_r;
    w_full_nxt   = w_full_r;
    aw_addr_nxt  = aw_addr_r;
    w_data_nxt   = w_data_r;
    w_strb0_nxt  = w_strb0_r;
    bvalid_nxt   = bvalid_r;
    bresp_nxt    = bresp_r;
    rvalid_nxt   = rvalid_r;
    rresp_nxt    = rresp_r;
    rdata_nxt    = rdata_r;
    ctrl_nxt     = ctrl_r;
    irq_mask_nxt = irq_mask_r;
    irq_sts_nxt  = irq_sts_r;

    if (s_axi_awvalid && !aw_full_r) begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_r) begin
      w_full_nxt  = 1'b1;
      w_data_nxt  = s_axi_wdata;
      w_strb0_nxt = s_axi_wstrb[0];
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_write) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = `LSH_RESP_OKAY;
      case (aw_addr_r)
        `LSH_OFF_CTRL: begin
          if (w_strb0_r) begin
            ctrl_nxt = lsh_ctrl_t'(w_data_r[7:0]);
          end
        end
        `LSH_OFF_STATUS: begin
          bresp_nxt = `LSH_RESP_OKAY;
        end
        `LSH_OFF_IRQ_STS: begin
          if (w_strb0_r) begin
            irq_sts_nxt = irq_sts_r & ~w_data_r[`LSH_IRQ_W-1:0];
          end
        end
        `LSH_OFF_IRQ_MASK: begin
          if (w_strb0_r) begin
            irq_mask_nxt = w_data_r[`LSH_IRQ_W-1:0];
          end
        end
        default: begin
          bresp_nxt = `LSH_RESP_SLVERR;
        end
      endcase
    end
    // A new event beats a clear in the same cycle
    irq_sts_nxt = irq_sts_nxt | events;

    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `LSH_RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      case (s_axi_araddr)
        `LSH_OFF_CTRL:     rdata_nxt[7:0] = ctrl_r;
        `LSH_OFF_STATUS: begin
          rdata_nxt[4:0]              = code_r;
          rdata_nxt[`LSH_ST_DROPOUT]  = drop_r;
          rdata_nxt[`LSH_ST_SETTLED]  = (hook_r == LSH_READY);
          rdata_nxt[`LSH_ST_OFFHOOK]  = offhook;
        end
        `LSH_OFF_IRQ_STS:  rdata_nxt[`LSH_IRQ_W-1:0] = irq_sts_r;
        `LSH_OFF_IRQ_MASK: rdata_nxt[`LSH_IRQ_W-1:0] = irq_mask_r;
        default:           rresp_nxt = `LSH_RESP_SLVERR;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  // Reset leaves the line on-hook in FCC termination
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_r       <= lsh_ctrl_t'(`LSH_CTRL_RESET);
      irq_sts_r    <= '0;
      irq_mask_r   <= '0;
      hook_r       <= LSH_ONHOOK;
      settle_cnt_r <= 11'h000;
      code_r       <= 5'h00;
      ovl_r        <= 1'b0;
      drop_r       <= 1'b0;
      aw_full_r    <= 1'b0;
      w_full_r     <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_data_r     <= 32'h0000_0000;
      w_strb0_r    <= 1'b0;
      bvalid_r     <= 1'b0;
      bresp_r      <= 2'h0;
      rvalid_r     <= 1'b0;
      rresp_r      <= 2'h0;
      rdata_r      <= 32'h0000_0000;
    end else begin
      ctrl_r       <= ctrl_nxt;
      irq_sts_r    <= irq_sts_nxt;
      irq_mask_r   <= irq_mask_nxt;
      hook_r       <= hook_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      code_r       <= code_nxt;
      ovl_r        <= ovl_nxt;
      drop_r       <= drop_nxt;
      aw_full_r    <= aw_full_nxt;
      w_full_r     <= w_full_nxt;
      aw_addr_r    <= aw_addr_nxt;
      w_data_r     <= w_data_nxt;
      w_strb0_r    <= w_strb0_nxt;
      bvalid_r     <= bvalid_nxt;
      bresp_r      <= bresp_nxt;
      rvalid_r     <= rvalid_nxt;
      rresp_r      <= rresp_nxt;
      rdata_r      <= rdata_nxt;
    end
  end
endmodule // lsh_line_sense

// file: testbench/lsh_line_model.sv
`timescale 1ns/10ps
// ----
// Line side stand-in
// ----
module lsh_line_model (
  input  wire logic       sys_clk,
  input  wire logic       hook_on,
  input  wire logic [8:0] volt_set,
  input  wire logic [7:0] curr_set,
  input  wire logic       line_ok,
  output logic [8:0]      line_volt_qv,
  output logic [7:0]      loop_current_ma,
  output logic            line_present,
  output logic            sample_tick
);
  logic [2:0] ph_r = 3'h0;
  // Sample strobe runs free, four cycles high and four low
  always_ff @(posedge sys_clk) begin
    ph_r <= ph_r + 3'h1;
  end
  assign sample_tick = ph_r[2];
  // No loop current can flow through an open hookswitch
  assign loop_current_ma = hook_on ? curr_set : 8'h00;
  assign line_volt_qv    = volt_set;
  assign line_present    = line_ok;
endmodule // lsh_line_model

// file: testbench/lsh_line_sense_assertions.sv
`timescale 1ns/10ps
`include "lsh_cfg.svh"
// ----
// Port checker
// ----
module lsh_line_sense_assertions #(
  parameter int SETTLE_SAMPLES = `LSH_SETTLE_FS
) (
  input wire logic          sys_clk,
  input wire logic          sys_rst,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic          sample_tick,
  input wire lsh_pkg::lsh_line_ctl_t line_ctl,
  input wire logic          line_data_valid
);
  import lsh_pkg::*;
  logic        tick_d_r;
  logic [11:0] cnt_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Count strobe edges since seizure; pin lag of the design allows one edge of slack
  always_ff @(posedge sys_clk) begin
    tick_d_r <= sample_tick;
    if (sys_rst || !line_ctl.hook_switch_on) begin
      cnt_r <= 12'h000;
    end else if (sample_tick && !tick_d_r) begin
      cnt_r <= cnt_r + 12'h001;
    end
  end
  AST_ARREADY: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready not the inverse of read valid");
  // The master keeps its ready high, so each answer must go once taken
  AST_BHOLD: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not withdrawn after it was taken");
  AST_RHOLD: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not withdrawn after it was taken");
  AST_BRESP: assert property (s_axi_bvalid |-> s_axi_bresp inside {`LSH_RESP_OKAY, `LSH_RESP_SLVERR})
    else $error("write response code unexpected");
  AST_EARLY: assert property (line_data_valid |-> cnt_r >= SETTLE_SAMPLES - 1)
    else $error("line data offered before settling");
  AST_LATE: assert property (line_ctl.hook_switch_on && cnt_r > SETTLE_SAMPLES |->
    line_data_valid)
    else $error("line data not offered after settling");
  AST_NOSEIZE: assert property (!line_ctl.hook_switch_on |-> !line_data_valid)
    else $error("line data offered while on-hook");
  AST_HOOKHOLD: assert property ($fell(line_ctl.hook_switch_on) |->
    s_axi_bvalid || $past(s_axi_bvalid))
    else $error("hookswitch opened without a write");
  AST_TXFS: assert property (line_ctl.tx_full_scale ==
    (line_ctl.dc_termination_select == LSH_DCT_LOWV ? LSH_TX_M5DBM :
     line_ctl.dc_termination_select == LSH_DCT_JAPAN ? LSH_TX_M271DBM : LSH_TX_M1DBM))
    else $error("transmit full scale does not match termination");
  AST_LIM: assert property (line_ctl.current_limit_on |-> line_ctl.dc_termination_select == LSH_DCT_CTR21)
    else $error("current limit outside the limiting mode");
endmodule // lsh_line_sense_assertions

bind lsh_line_sense lsh_line_sense_assertions #(.SETTLE_SAMPLES(SETTLE_SAMPLES)) u_chk (.sys_clk, .sys_rst,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .sample_tick, .line_ctl, .line_data_valid);

// file: testbench/testbench.sv
`timescale 1ns/10ps
`include "lsh_cfg.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
// ----
// Register level tests
// ----
module testbench;
  import lsh_pkg::*;
  logic          sys_clk, sys_rst, line_present, sample_tick, line_ok, irq, line_data_valid;
  logic [7:0]    s_axi_awaddr, s_axi_araddr, loop_current_ma, curr_set;
  logic [31:0]   s_axi_wdata, s_axi_rdata, d;
  logic [3:0]    s_axi_wstrb;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic          s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]    s_axi_bresp, s_axi_rresp, r;
  logic [8:0]    line_volt_qv, volt_set;
  lsh_line_ctl_t line_ctl;
  int            error_cnt = 0, checked = 0, cyc = 0;
  logic [8:0]    vq [6] = '{9'h000, 9'h00b, 9'h00c, 9'h016, 9'h017, 9'h15c};
  logic [4:0]    vc [6] = '{5'h00, 5'h00, 5'h01, 5'h01, 5'h02, 5'h1f};
  logic [7:0]    ci [7] = '{8'h00, 8'h03, 8'h1d, 8'h8c, 8'h8d, 8'h36, 8'h37};
  logic [4:0]    ce [7] = '{5'h00, 5'h01, 5'h09, 5'h1e, 5'h1f, 5'h12, 5'h1f};
  logic [7:0]    cm [7] = '{8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h39, 8'h39};
  lsh_txfs_t     txe [4] = '{LSH_TX_M5DBM, LSH_TX_M271DBM, LSH_TX_M1DBM, LSH_TX_M1DBM};
  // Seize-to-switch hold, far shorter than the real half second to keep the run short
  localparam int HOLD_CYC = 200;

  lsh_line_sense #(.SETTLE_SAMPLES(4)) dut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_volt_qv, .loop_current_ma, .line_present,
    .sample_tick, .line_ctl, .line_data_valid, .irq);
  lsh_line_model u_line (.sys_clk, .hook_on(line_ctl.hook_switch_on), .volt_set, .curr_set,
    .line_ok, .line_volt_qv, .loop_current_ma, .line_present, .sample_tick);

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  task automatic give_verdict();
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // A hang counts as a mismatch; the whole run needs a few thousand cycles at most
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // Write: both channels and bready raised together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Read: rready held high from the request, data taken at the edge rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(a, v, rs);
    `CHK("register", e, v & m)
  endtask

  // Low-voltage seizure with trim, then pick the termination from the loop current
  task automatic lv_pick(input logic [7:0] ma, input logic [7:0] e);
    logic [31:0] v;
    logic [1:0]  rs;
    wr(`LSH_OFF_CTRL, 32'h41, rs);
    curr_set <= ma;
    repeat (4) @(posedge sys_clk);
    rd(`LSH_OFF_STATUS, v, rs);
    if (v[4:0] > 5'h05) wr(`LSH_OFF_CTRL, 32'h11, rs);
    else if (v[4:0] > 5'h02) wr(`LSH_OFF_CTRL, 32'h49, rs);
    rc(`LSH_OFF_CTRL, 32'hff, 32'(e));
    `CHK("trim", e[6], line_ctl.low_voltage_trim)
  endtask

  // Main sequence
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, volt_set, curr_set} = '0;
    s_axi_wstrb = 4'hf;
    line_ok = 1'b1;
    sys_rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rc(`LSH_OFF_CTRL, 32'hff, 32'h10);
    `CHK("dct", LSH_DCT_FCC, line_ctl.dc_termination_select)
    wr(`LSH_OFF_CTRL, 32'h12, r);
    for (int i = 0; i < 6; i++) begin
      volt_set <= vq[i];
      repeat (4) @(posedge sys_clk);
      rc(`LSH_OFF_STATUS, 32'h1f, 32'(vc[i]));
    end
    wr(`LSH_OFF_CTRL, 32'h10, r);
    rc(`LSH_OFF_STATUS, 32'h1f, 32'h0);
    wr(`LSH_OFF_IRQ_MASK, 32'h1, r);
    wr(`LSH_OFF_CTRL, 32'h11, r);
    rc(`LSH_OFF_STATUS, 32'h600, 32'h400);
    while (!line_data_valid) @(posedge sys_clk);
    @(posedge sys_clk);
    `CHK("irq", 1'b1, irq)
    rc(`LSH_OFF_STATUS, 32'h600, 32'h600);
    wr(`LSH_OFF_IRQ_MASK, 32'h0, r);
    `CHK("irq", 1'b0, irq)
    wr(`LSH_OFF_IRQ_MASK, 32'h1, r);
    `CHK("irq", 1'b1, irq)
    wr(`LSH_OFF_IRQ_STS, 32'h1, r);
    `CHK("irq", 1'b0, irq)
    rc(`LSH_OFF_IRQ_STS, 32'h1, 32'h0);
    for (int i = 0; i < 7; i++) begin
      wr(`LSH_OFF_CTRL, 32'(cm[i]), r);
      curr_set <= ci[i];
      repeat (4) @(posedge sys_clk);
      rc(`LSH_OFF_STATUS, 32'h1f, 32'(ce[i]));
    end
    `CHK("limit", 1'b1, line_ctl.current_limit_on)
    curr_set <= 8'h0f;
    repeat (4) @(posedge sys_clk);
    rd(`LSH_OFF_STATUS, d, r);
    if (d[4:0] < 5'h06) wr(`LSH_OFF_CTRL, 32'h11, r);
    rc(`LSH_OFF_CTRL, 32'hff, 32'h11);
    lv_pick(8'h06, 8'h41);
    lv_pick(8'h0c, 8'h49);
    lv_pick(8'h12, 8'h11);
    line_ok <= 1'b0;
    curr_set <= 8'h00;
    repeat (4) @(posedge sys_clk);
    rc(`LSH_OFF_STATUS, 32'h11f, 32'h100);
    rc(`LSH_OFF_IRQ_STS, 32'h6, 32'h6);
    wr(`LSH_OFF_STATUS, 32'hffffffff, r);
    `CHK("bresp", `LSH_RESP_OKAY, r)
    rc(`LSH_OFF_STATUS, 32'h11f, 32'h100);
    line_ok <= 1'b1;
    wr(8'h10, 32'h1, r);
    `CHK("bresp", `LSH_RESP_SLVERR, r)
    rd(8'h10, d, r);
    `CHK("rresp", `LSH_RESP_SLVERR, r)
    `CHK("rdata", 32'h0, d)
    for (int k = 0; k < 4; k++) begin
      wr(`LSH_OFF_CTRL, 32'(((k & 1) << 7) | (k << 3)), r);
      `CHK("hook", 1'b0, line_ctl.hook_switch_on)
      `CHK("dct", 2'(k), line_ctl.dc_termination_select)
      `CHK("txfs", txe[k], line_ctl.tx_full_scale)
      `CHK("ac", 1'(k & 1), line_ctl.ac_term_complex)
    end
    wr(`LSH_OFF_CTRL, 32'h09, r);
    `CHK("txfs", LSH_TX_M271DBM, line_ctl.tx_full_scale)
    repeat (HOLD_CYC) @(posedge sys_clk);
    wr(`LSH_OFF_CTRL, 32'h11, r);
    `CHK("hook", 1'b1, line_ctl.hook_switch_on)
    `CHK("txfs", LSH_TX_M1DBM, line_ctl.tx_full_scale)
    give_verdict();
  end
endmodule // testbench
